// file: lsl_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module lsl_ctrl_model (
	input wire logic sys_clk,
	output logic serial_in,
	output logic shift_clock,
	output logic latch_strobe
);
	initial begin
		serial_in = 1'b0;
		shift_clock = 1'b0;
		latch_strobe = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic send(input logic [256:0] w);
		for (int i = 256; i >= 0; i--) begin
			serial_in = w[i];
			wt(4);
			shift_clock = 1'b1;
			wt(4);
			shift_clock = 1'b0;
		end
		// Inverted so a stale bit cannot pass
		serial_in = ~serial_in;
		wt(4);
		latch_strobe = 1'b1;
		wt(4);
		latch_strobe = 1'b0;
		wt(4);
	endtask
endmodule
`default_nettype wire

// file: lsl_defines.vh
`ifndef LSL_DEFINES_VH
`define LSL_DEFINES_VH
`define LSL_SR_W 257
`define LSL_SR_TOP 256
`define LSL_GS_W 256
`define LSL_CTL1_W 137
`define LSL_CTL2_W 119
`define LSL_CH_N 16
`define LSL_GS_FW 16
`define LSL_DC_FW 7
`define LSL_DC_W 112
`define LSL_BC_LSB 112
`define LSL_BC_MSB 118
`define LSL_BLANK_BIT 119
`define LSL_RPT_BIT 120
`define LSL_TMG_BIT 121
`define LSL_PSAVE_BIT 136
`define LSL_CNT_W 16
`define LSL_CNT_MAX 16'hFFFF
`endif

// file: lsl_edge_sync.v
`timescale 1ns/100ps
`default_nettype none
`include "lsl_defines.vh"
module lsl_edge_sync (
	input wire sys_clk,
	input wire rst,
	input wire async_in,
	output wire level,
	output wire rise
);
	reg meta_q;
	reg sync_q;
	reg prev_q;
	always @(posedge sys_clk) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
endmodule
`default_nettype wire

// file: lsl_pwm_chan.v
`timescale 1ns/100ps
`default_nettype none
`include "lsl_defines.vh"
module lsl_pwm_chan (
	input wire sys_clk,
	input wire rst,
	input wire [15:0] on_count,
	input wire [15:0] gs_count,
	input wire run,
	output reg out_on
);
	// Conventional PWM: on while counter below grayscale value
	always @(posedge sys_clk) begin
		if (rst) begin
			out_on <= 1'b0;
		end else begin
			out_on <= run & (gs_count < on_count);
		end
	end
endmodule
`default_nettype wire

// file: lsl_shift_latch_bank.v
`timescale 1ns/100ps
`default_nettype none
`include "lsl_defines.vh"
// Summary of operation
// RULE1 - Timing reset strobe clears counter, outputs off
// RULE2 - Timing reset strobe loads both grayscale latches
// RULE3 - Timing reset strobe moves correction, brightness
// RULE4 - PWM restarts at next display clock
// RULE5 - Without timing reset, strobe leaves timing alone
// RULE6 - Shift clock shifts serial input upward
// RULE7 - Top shift bit drives serial output
// RULE8 - Top bit zero: strobe loads grayscale latch
// RULE9 - Top bit one: strobe loads control latch
// RULE10 - Second grayscale latch updated three ways
// RULE11 - Second control latch updated at period end
// RULE12 - On-time from second grayscale latch only
// RULE13 - Correction, brightness from second control latch
// RULE14 - Grayscale channel n at bits 16n+15..16n
// RULE15 - Correction channel n at bits 7n+6..7n
// RULE16 - Brightness at control bits 118..112
// RULE17 - Blank bit comes up set
// RULE18 - Controller loads grayscale before enabling outputs
// RULE19 - Controller loads control latches before enabling
// RULE20 - Control latches 137 and 119 bits
// RULE21 - Blank forces off, holds counter zero
// RULE22 - Auto repeat restarts every 65536 clocks
// RULE23 - Bit 121 selects timing reset
// RULE24 - Strobe during blank loads both latches
// RULE25 - Sixteen-bit counter wraps at period end
// RULE26 - Target chosen by top bit at edge
module lsl_shift_latch_bank (
	input wire sys_clk,
	input wire rst,
	input wire serial_in,
	input wire shift_clock,
	input wire latch_strobe,
	input wire display_clock,
	output wire serial_out,
	output wire [15:0] channel_on,
	output reg [111:0] dot_correction_q,
	output reg [6:0] global_brightness_q,
	output reg [255:0] grayscale_active_q,
	output reg [15:0] gs_counter_q,
	output reg blank_q,
	output reg power_save_bit_q,
	output reg period_done_q
);
	wire sin_lvl;
	wire sclk_rise;
	wire lat_rise;
	wire gck_rise;
	reg [`LSL_SR_W-1:0] common_shift_register_q;
	reg [`LSL_GS_W-1:0] first_grayscale_latch_q;
	reg [`LSL_CTL1_W-1:0] first_control_latch_q;
	reg run_q;
	reg restart_q;
	wire [`LSL_CTL1_W-1:0] ctl_new;
	wire gs_write;
	wire ctl_write;
	wire tmg_en;
	wire rpt_en;
	wire wrap;
	wire tmg_reset;

	// Strobe decode shared by both write targets
	function strobe_hit;
		input strobe;
		input top;
		input want;
		begin
			strobe_hit = strobe & (top == want);
		end
	endfunction

	// Channel n field of a latch, channel 0 in the lowest bits
	function [15:0] gs_field;
		input [`LSL_GS_W-1:0] v;
		input integer idx;
		begin
			gs_field = v[idx*`LSL_GS_FW +: `LSL_GS_FW];
		end
	endfunction

	// Data and shift clock share one synchroniser depth so data stays aligned
	lsl_edge_sync u_sin (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(serial_in),
		.level(sin_lvl),
		.rise()
	);
	lsl_edge_sync u_sclk (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(shift_clock),
		.level(),
		.rise(sclk_rise)
	);
	lsl_edge_sync u_lat (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(latch_strobe),
		.level(),
		.rise(lat_rise)
	);
	lsl_edge_sync u_gck (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(display_clock),
		.level(),
		.rise(gck_rise)
	);

	// RULE26 top bit select
	assign gs_write = strobe_hit(lat_rise, common_shift_register_q[`LSL_SR_TOP], 1'b0);
	assign ctl_write = strobe_hit(lat_rise, common_shift_register_q[`LSL_SR_TOP], 1'b1);
	assign ctl_new = common_shift_register_q[`LSL_CTL1_W-1:0];
	// RULE23 timing reset bit
	assign tmg_en = first_control_latch_q[`LSL_TMG_BIT];
	// RULE22 repeat bit
	assign rpt_en = first_control_latch_q[`LSL_RPT_BIT];
	// RULE1 timing reset event
	// RULE5 gated by enable
	assign tmg_reset = gs_write & tmg_en;
	// RULE25 wrap at maximum
	assign wrap = gck_rise & run_q & (gs_counter_q == `LSL_CNT_MAX);

	// Next values; every register below loads its next value each cycle
	reg [`LSL_SR_W-1:0] common_shift_register_d;
	reg [`LSL_GS_W-1:0] first_grayscale_latch_d;
	reg [`LSL_CTL1_W-1:0] first_control_latch_d;
	reg blank_d;
	reg power_save_bit_d;
	reg [`LSL_GS_W-1:0] grayscale_active_d;
	reg [`LSL_DC_W-1:0] dot_correction_d;
	reg [6:0] global_brightness_d;
	reg [15:0] gs_counter_d;
	reg run_d;
	reg restart_d;
	reg period_done_d;
	wire chan_run;

	// RULE6 shift on clock edge
	always @* begin
		common_shift_register_d = common_shift_register_q;
		if (sclk_rise) begin
			common_shift_register_d = {common_shift_register_q[`LSL_SR_W-2:0], sin_lvl};
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			common_shift_register_q <= {`LSL_SR_W{1'b0}};
		end else begin
			common_shift_register_q <= common_shift_register_d;
		end
	end
	// RULE7 serial output
	assign serial_out = common_shift_register_q[`LSL_SR_TOP];

	// RULE8 grayscale first latch
	always @* begin
		first_grayscale_latch_d = first_grayscale_latch_q;
		if (gs_write) begin
			first_grayscale_latch_d = common_shift_register_q[`LSL_GS_W-1:0];
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			first_grayscale_latch_q <= {`LSL_GS_W{1'b0}};
		end else begin
			first_grayscale_latch_q <= first_grayscale_latch_d;
		end
	end

	// RULE9 control first latch
	// RULE20 137-bit latch
	always @* begin
		first_control_latch_d = first_control_latch_q;
		blank_d = blank_q;
		power_save_bit_d = power_save_bit_q;
		if (ctl_write) begin
			first_control_latch_d = ctl_new;
			blank_d = ctl_new[`LSL_BLANK_BIT];
			power_save_bit_d = ctl_new[`LSL_PSAVE_BIT];
		end
	end

	// RULE17 blank set at reset
	always @(posedge sys_clk) begin
		if (rst) begin
			first_control_latch_q <= {{(`LSL_CTL1_W-`LSL_BLANK_BIT-1){1'b0}}, 1'b1,
				{`LSL_BLANK_BIT{1'b0}}};
			blank_q <= 1'b1;
			power_save_bit_q <= 1'b0;
		end else begin
			first_control_latch_q <= first_control_latch_d;
			blank_q <= blank_d;
			power_save_bit_q <= power_save_bit_d;
		end
	end

	// RULE10 second grayscale update
	// RULE2 both latches at once
	// RULE24 blank loads both
	always @* begin
		grayscale_active_d = grayscale_active_q;
		if (gs_write & (tmg_en | blank_q)) begin
			grayscale_active_d = common_shift_register_q[`LSL_GS_W-1:0];
		end else if (blank_q | (wrap & rpt_en)) begin
			grayscale_active_d = first_grayscale_latch_q;
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			grayscale_active_q <= {`LSL_GS_W{1'b0}};
		end else begin
			grayscale_active_q <= grayscale_active_d;
		end
	end

	// RULE11 second control update
	// RULE3 moved on timing reset
	// RULE15 correction field
	// RULE16 brightness field
	always @* begin
		dot_correction_d = dot_correction_q;
		global_brightness_d = global_brightness_q;
		if (ctl_write & blank_q) begin
			dot_correction_d = ctl_new[`LSL_DC_W-1:0];
			global_brightness_d = ctl_new[`LSL_BC_MSB:`LSL_BC_LSB];
		end else if (blank_q | wrap | tmg_reset) begin
			dot_correction_d = first_control_latch_q[`LSL_DC_W-1:0];
			global_brightness_d = first_control_latch_q[`LSL_BC_MSB:`LSL_BC_LSB];
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			dot_correction_q <= {`LSL_DC_W{1'b0}};
			global_brightness_q <= 7'h00;
		end else begin
			dot_correction_q <= dot_correction_d;
			global_brightness_q <= global_brightness_d;
		end
	end

	// Counter and run state; a timing reset waits for the next display clock
	always @* begin
		gs_counter_d = gs_counter_q;
		run_d = run_q;
		restart_d = restart_q;
		period_done_d = period_done_q;
		if (blank_q | tmg_reset) begin
			// RULE21 blank holds zero
			// RULE1 counter cleared
			gs_counter_d = 16'h0000;
			run_d = 1'b0;
			restart_d = 1'b1;
			period_done_d = 1'b0;
		end else if (gck_rise) begin
			if (restart_q) begin
				// RULE4 restart with counter at one
				restart_d = 1'b0;
				run_d = 1'b1;
				gs_counter_d = 16'h0001;
				period_done_d = 1'b0;
			end else if (wrap) begin
				// RULE22 repeat or stop
				gs_counter_d = 16'h0000;
				run_d = rpt_en;
				period_done_d = ~rpt_en;
			end else if (run_q) begin
				gs_counter_d = gs_counter_q + 16'h0001;
			end
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			gs_counter_q <= 16'h0000;
			run_q <= 1'b0;
			restart_q <= 1'b0;
			period_done_q <= 1'b0;
		end else begin
			gs_counter_q <= gs_counter_d;
			run_q <= run_d;
			restart_q <= restart_d;
			period_done_q <= period_done_d;
		end
	end

	// Gate on the strobe itself so the channels drop in the same cycle the counter clears
	assign chan_run = run_q & ~blank_q & ~tmg_reset;

	// RULE12 on-time from second latch
	// RULE14 channel field layout
	genvar n;
	generate
		for (n = 0; n < `LSL_CH_N; n = n + 1) begin : g_ch
			wire [15:0] on_count;
			assign on_count = gs_field(grayscale_active_q, n);
			lsl_pwm_chan u_ch (
				.sys_clk(sys_clk),
				.rst(rst),
				.on_count(on_count),
				.gs_count(gs_counter_q),
				.run(chan_run),
				.out_on(channel_on[n])
			);
		end
	endgenerate
	// RULE13 correction outputs registered above
endmodule
`default_nettype wire

// file: lsl_shift_latch_bank_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module lsl_sva (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic shift_clock,
	input wire logic serial_out,
	input wire logic [15:0] channel_on,
	input wire logic [111:0] dot_correction_q,
	input wire logic [6:0] global_brightness_q,
	input wire logic [255:0] grayscale_active_q,
	input wire logic [15:0] gs_counter_q,
	input wire logic blank_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_quiet;
		$stable(shift_clock) [*6];
	endsequence
	sequence s_blank;
		blank_q [*3];
	endsequence
	property p_rst_val;
		$past(rst) |-> blank_q && gs_counter_q == 16'h0000;
	endproperty
	a_rst_val: assert property (p_rst_val) else $error("bad reset value");
	property p_blank_off;
		s_blank |-> channel_on == 16'h0000;
	endproperty
	a_blank_off: assert property (p_blank_off) else $error("output on in blank");
	property p_blank_cnt;
		s_blank |-> gs_counter_q == 16'h0000;
	endproperty
	a_blank_cnt: assert property (p_blank_cnt) else $error("counter runs in blank");
	property p_cnt_step;
		$changed(gs_counter_q) |->
			gs_counter_q == $past(gs_counter_q) + 16'h0001 || gs_counter_q == 16'h0000;
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("counter jump");
	property p_pwm_on;
		channel_on[0] |-> $past(gs_counter_q) < $past(grayscale_active_q[15:0]);
	endproperty
	a_pwm_on: assert property (p_pwm_on) else $error("channel on late");
	property p_gs_hold;
		$changed(grayscale_active_q) |->
			blank_q || $past(blank_q) || gs_counter_q == 16'h0000;
	endproperty
	a_gs_hold: assert property (p_gs_hold) else $error("grayscale moved");
	property p_ctl_hold;
		$changed({dot_correction_q, global_brightness_q}) |->
			blank_q || $past(blank_q) || gs_counter_q == 16'h0000;
	endproperty
	a_ctl_hold: assert property (p_ctl_hold) else $error("control moved");
	property p_shift_quiet;
		s_quiet |=> $stable(serial_out);
	endproperty
	a_shift_quiet: assert property (p_shift_quiet) else $error("stray shift");
endmodule
bind lsl_shift_latch_bank lsl_sva i_sva (.sys_clk, .rst, .shift_clock, .serial_out,
	.channel_on, .dot_correction_q, .global_brightness_q, .grayscale_active_q,
	.gs_counter_q, .blank_q);
`default_nettype wire

// file: tb_lsl_shift_latch_bank.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
	$display("ERROR %0t value mismatch", $time); end end
module tb_lsl_shift_latch_bank;
	logic sys_clk, rst, display_clock, serial_in, shift_clock, latch_strobe, serial_out, blank_q;
	logic [15:0] channel_on, gs_counter_q;
	logic [111:0] dot_correction_q, dc;
	logic [6:0] global_brightness_q, bc;
	logic [255:0] grayscale_active_q, g;
	logic [257:0] exp_q[$], e;
	integer seed, n_mismatch, cmp_count;
	event probe;
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	lsl_ctrl_model i_ctl (.sys_clk(sys_clk), .serial_in(serial_in),
		.shift_clock(shift_clock), .latch_strobe(latch_strobe));
	lsl_shift_latch_bank i_dut (.sys_clk(sys_clk), .rst(rst), .serial_in(serial_in),
		.shift_clock(shift_clock), .latch_strobe(latch_strobe), .display_clock(display_clock),
		.serial_out(serial_out), .channel_on(channel_on), .dot_correction_q(dot_correction_q),
		.global_brightness_q(global_brightness_q), .grayscale_active_q(grayscale_active_q),
		.gs_counter_q(gs_counter_q), .blank_q(blank_q), .power_save_bit_q(),
		.period_done_q());
	function automatic logic [255:0] got(input logic [1:0] s);
		case (s)
			2'h0: got = grayscale_active_q;
			2'h1: got = {144'h0, dot_correction_q};
			2'h2: got = {249'h0, global_brightness_q};
			default: got = {238'h0, serial_out, blank_q, gs_counter_q};
		endcase
	endfunction
	task automatic expect_v(input logic [1:0] s, input logic [255:0] v);
		exp_q.push_back({s, v});
	endtask
	task automatic settle();
		repeat (8) @(negedge sys_clk);
		-> probe;
		@(negedge sys_clk);
	endtask
	task automatic new_g();
		for (int i = 0; i < 8; i++) g[i*32+:32] = $random(seed);
		dc = g[111:0];
		bc = g[118:112];
	endtask
	task automatic dpulse(input int n);
		repeat (n) begin
			display_clock = 1'b1;
			repeat (8) @(negedge sys_clk);
			display_clock = 1'b0;
			repeat (8) @(negedge sys_clk);
		end
	endtask
	task automatic ctl(input logic blank, input logic tmg);
		i_ctl.send({1'b1, 134'h0, tmg, 1'b1, blank, bc, dc});
	endtask
	always @(probe) begin
		while (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			`CHK(got(e[257:256]), e[255:0])
		end
	end
	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		#400000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		seed = 32'h0524;
		n_mismatch = 0;
		cmp_count = 0;
		rst = 1'b1;
		display_clock = 1'b0;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		expect_v(2'h3, {238'h0, 1'b0, 1'b1, 16'h0000});
		settle();
		new_g();
		ctl(1'b1, 1'b1);
		expect_v(2'h1, {144'h0, dc});
		expect_v(2'h2, {249'h0, bc});
		settle();
		new_g();
		i_ctl.send({1'b0, g});
		expect_v(2'h0, g);
		settle();
		new_g();
		ctl(1'b0, 1'b1);
		dpulse(5);
		expect_v(2'h3, {238'h0, 1'b1, 1'b0, 16'h0005});
		settle();
		i_ctl.send({1'b0, g});
		expect_v(2'h0, g);
		expect_v(2'h3, {238'h0, 1'b0, 1'b0, 16'h0000});
		expect_v(2'h1, {144'h0, dc});
		settle();
		dpulse(1);
		expect_v(2'h3, {238'h0, 1'b0, 1'b0, 16'h0001});
		settle();
		tally_and_finish();
	end
endmodule
`default_nettype wire
